/* src/fir_ctrl_map.svh */
// Purpose: offsets, field positions, fixed words and timing counts for the fir host controller
// Assumes: 25 MHz clock, device port is write-only
// Notes:   definitions only
`ifndef FIR_CTRL_MAP_SVH
`define FIR_CTRL_MAP_SVH

// ----------------------------------------------------------------
// device register map
// ----------------------------------------------------------------
`define ADDR_FILTER_CONFIG_WORD 9'h000
`define ADDR_FILTER_OPTION_WORD 9'h001
`define ADDR_COEF_BANK_BASE     9'h100
`define COEF_SET_STRIDE         9'h008
`define COEF_CELL_B_OFFSET      9'h004

// ----------------------------------------------------------------
// config and option word fields, fixed config words
// ----------------------------------------------------------------
`define CFG_DEC_LSB             0
`define CFG_DEC_W               4
`define CFG_CELL_A_EVEN_BIT     6
`define CFG_CELL_B_EVEN_BIT     7
`define OPT_REVERSAL_OFF_BIT    4
`define CFG_WORD_EVEN_DEC3      10'h1d2
`define CFG_WORD_ODD_DEC3       10'h112
`define CFG_WORD_MUX_DEC3       10'h152

// ----------------------------------------------------------------
// output select codes
// ----------------------------------------------------------------
`define OUT_SEL_CELL_A          2'h1
`define OUT_SEL_CELL_B          2'h2

// ----------------------------------------------------------------
// timing and decimation limit
// ----------------------------------------------------------------
`define CLK_PERIOD_NS           40
`define T_ADDR_SETUP_NS         10
`define T_WR_LOW_NS             12
`define T_WR_HIGH_NS            12
`define CYCLES_MIN(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAX_DEC_FACTOR          16

`endif

/* src/fir_ctrl_pkg.sv */
// Purpose: shared types for the fir host controller
// Assumes: constants live in fir_ctrl_map.svh
// Notes:   none
package fir_ctrl_pkg;

  typedef struct packed {
    logic       lifo_swap_strobe;
    logic       accum_keep;
    logic [4:0] coef_set_select;
    logic [1:0] output_select;
    logic       shift_hold;
    logic       fwd_path_gate;
    logic       rev_path_gate;
  } strobe_t;

  typedef struct packed {
    logic [8:0] addr;
    logic [9:0] data;
  } cfg_write_t;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_SETUP,
    WR_LOW,
    WR_HOLD
  } wr_state_t;

endpackage

/* src/cfg_port_writer.sv */
// Purpose: drives one write cycle on the device parallel config port
// Assumes: request comes from logic on the same clock
// Notes:   address and data held from setup through hold phase
`timescale 1ns/1ps
`include "fir_ctrl_map.svh"

module cfg_port_writer
  import fir_ctrl_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       req_valid,
  output      logic       req_ready,
  input  wire cfg_write_t req,
  output      logic [8:0] cfg_addr,
  output      logic [9:0] cfg_data_in,
  output      logic       cfg_wr_n,
  output      logic       done
);

  localparam logic [1:0] SETUP_CYC = 2'(`CYCLES_MIN(`T_ADDR_SETUP_NS));
  localparam logic [1:0] LOW_CYC   = 2'(`CYCLES_MIN(`T_WR_LOW_NS));
  localparam logic [1:0] HIGH_CYC  = 2'(`CYCLES_MIN(`T_WR_HIGH_NS));

  wr_state_t  state;
  wr_state_t  next_state;
  logic [1:0] count;
  logic       count_end;
  logic       take;

  assign req_ready = (state == WR_IDLE);
  assign take      = req_valid && req_ready;
  assign count_end = (count == 2'h1);
  assign done      = (state == WR_HOLD) && count_end;

  always_comb begin
    next_state = state;
    unique case (state)
      WR_IDLE:  if (take) next_state = WR_SETUP;
      WR_SETUP: if (count_end) next_state = WR_LOW;
      WR_LOW:   if (count_end) next_state = WR_HOLD;
      WR_HOLD:  if (count_end) next_state = WR_IDLE;
    endcase
  end

  // address set up before strobe falls, data held past its rise
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state       <= WR_IDLE;
      count       <= 2'h0;
      cfg_addr    <= 9'h000;
      cfg_data_in <= 10'h000;
      cfg_wr_n    <= 1'b1;
    end else begin
      state <= next_state;
      if (take) begin
        cfg_addr    <= req.addr;
        cfg_data_in <= req.data;
        count       <= SETUP_CYC;
      end else if (next_state != state) begin
        count <= (next_state == WR_LOW) ? LOW_CYC : HIGH_CYC;
      end else if (!count_end) begin
        count <= count - 2'h1;
      end
      cfg_wr_n <= !(next_state == WR_LOW);
    end
  end

endmodule // cfg_port_writer

/* src/fir_host_ctrl.sv */
// Purpose: host controller for a dual decimating symmetric fir device
// Assumes: single 25 MHz clock; device port write-only; user side on same clock
// Notes:   snoops its own config writes to learn the decimation factor
//
// Contract
// - swap strobe once every n clocks (the controller issues none when n is 1)
// - accum_keep low once every n clocks
// - coefficient set cycles through n sets
// - odd mode: swap one clock earlier
// - host stores centre coefficient halved (the controller passes coefficients untouched; the user halves the centre tap)
// - even dec3 config word is 1d2
// - odd dec3 config word is 112
// - mixed mux dec3 config word is 152
// - writes present address, data, write strobe
// - mux select: odd result first, even second
`timescale 1ns/1ps
`include "fir_ctrl_map.svh"

module fir_host_ctrl
  import fir_ctrl_pkg::*;
#(
  parameter int MAX_DEC = `MAX_DEC_FACTOR
)(
  input  wire logic       clock,
  input  wire logic       rst,
  // user write requests
  input  wire logic       cmd_valid,
  output      logic       cmd_ready,
  input  wire logic [1:0] cmd_kind,
  input  wire logic [8:0] cmd_addr,
  input  wire logic [9:0] cmd_data,
  output      logic       cmd_done,
  // user run control
  input  wire logic       run,
  input  wire logic       mux_enable,
  input  wire logic [4:0] coef_base,
  input  wire logic [1:0] fixed_select,
  output      logic [4:0] dec_factor,
  output      logic       odd_mode,
  // device pins
  output      logic [8:0] cfg_addr,
  output      logic [9:0] cfg_data_in,
  output      logic       cfg_wr_n,
  output      strobe_t    strobes
);

  generate
    if (MAX_DEC < 1 || MAX_DEC > `MAX_DEC_FACTOR) begin : g_bad_dec
      $error("MAX_DEC out of range");
    end
  endgenerate

  // ----------------------------------------------------------------
  // command shaping
  // ----------------------------------------------------------------
  // cmd_kind: 0 raw word, 1 coefficient (addr = set*8+tap), 2 dec field only
  // coefficient index: set in [7:3], cell b in [2], tap in [1:0]
  function automatic logic [8:0] coef_addr(input logic [8:0] idx);
    coef_addr = `ADDR_COEF_BANK_BASE + (idx & 9'h0ff);
  endfunction

  function automatic logic [9:0] dec_word(input logic [9:0] n);
    dec_word = (n - 10'h001) & 10'h00f;
  endfunction

  cfg_write_t shaped;
  logic       writer_ready;
  logic       writer_done;
  logic       take;
  cfg_write_t last_req;
  logic       pending_cfg;

  assign shaped.addr = (cmd_kind == 2'h1) ? coef_addr(cmd_addr)
                     : (cmd_kind == 2'h2) ? `ADDR_FILTER_CONFIG_WORD
                     : cmd_addr;
  // coefficients pass untouched: the user halves the odd-length centre tap
  assign shaped.data = (cmd_kind == 2'h2) ? dec_word(cmd_data) : cmd_data;
  assign cmd_ready   = writer_ready;
  assign take        = cmd_valid && writer_ready;

  cfg_port_writer u_writer (
    .clock       (clock),
    .rst         (rst),
    .req_valid   (cmd_valid),
    .req_ready   (writer_ready),
    .req         (shaped),
    .cfg_addr    (cfg_addr),
    .cfg_data_in (cfg_data_in),
    .cfg_wr_n    (cfg_wr_n),
    .done        (writer_done)
  );

  // ----------------------------------------------------------------
  // config snoop
  // ----------------------------------------------------------------
  // the port is write-only, so the mode is learned from what we wrote
  logic [9:0] cfg_shadow;
  logic [4:0] next_dec;
  logic       clamp;

  // 1d2 / 112 / 152 differ only in the cell even bits
  assign odd_mode = !(cfg_shadow[`CFG_CELL_A_EVEN_BIT] && cfg_shadow[`CFG_CELL_B_EVEN_BIT]);
  assign next_dec = 5'(cfg_shadow[`CFG_DEC_LSB +: `CFG_DEC_W]) + 5'h01;
  assign clamp    = (32'(next_dec) > MAX_DEC);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last_req    <= '0;
      pending_cfg <= 1'b0;
      cfg_shadow  <= 10'h000;
      cmd_done    <= 1'b0;
    end else begin
      cmd_done <= writer_done;
      if (take) begin
        last_req    <= shaped;
        pending_cfg <= (shaped.addr == `ADDR_FILTER_CONFIG_WORD);
      end
      if (writer_done && pending_cfg) begin
        cfg_shadow <= last_req.data;
      end
    end
  end

  // ----------------------------------------------------------------
  // per-clock strobe sequencer
  // ----------------------------------------------------------------
  logic [4:0] phase;
  logic [4:0] n_eff;
  logic [4:0] last_phase;
  logic       period_start;
  logic       swap_now;
  logic [1:0] odd_sel;
  logic [1:0] even_sel;
  logic [1:0] next_sel;
  strobe_t    next_strobes;

  assign dec_factor   = clamp ? 5'(MAX_DEC) : next_dec;
  assign n_eff        = dec_factor;
  assign last_phase   = n_eff - 5'h01;
  assign period_start = (phase == 5'h00);
  // odd mode: device holds swap one clock, so issue it a clock early
  assign swap_now     = odd_mode ? (phase == last_phase) : period_start;
  // cell a even per its config bit; otherwise b carries the even filter
  assign odd_sel      = cfg_shadow[`CFG_CELL_A_EVEN_BIT] ? `OUT_SEL_CELL_B : `OUT_SEL_CELL_A;
  assign even_sel     = cfg_shadow[`CFG_CELL_A_EVEN_BIT] ? `OUT_SEL_CELL_A : `OUT_SEL_CELL_B;
  assign next_sel     = !mux_enable ? fixed_select
                      : period_start ? odd_sel : even_sel;

  always_comb begin
    next_strobes                  = '0;
    next_strobes.lifo_swap_strobe = run && swap_now && (n_eff != 5'h01);
    // low on the first clock of each period restarts the sum
    next_strobes.accum_keep       = run && !period_start;
    next_strobes.coef_set_select  = coef_base + phase;
    next_strobes.output_select    = next_sel;
    next_strobes.shift_hold       = 1'b0;
    next_strobes.fwd_path_gate    = 1'b0;
    next_strobes.rev_path_gate    = 1'b0;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase   <= 5'h00;
      strobes <= '0;
    end else begin
      strobes <= next_strobes;
      if (!run || phase >= last_phase) begin
        phase <= 5'h00;
      end else begin
        phase <= phase + 5'h01;
      end
    end
  end

endmodule // fir_host_ctrl

/* tb/fir_host_chk.sv */
// Purpose: port assertions for fir_host_ctrl
// Assumes: strobes lag the sequencer phase by one clock
// Notes:   run_q marks strobes made while run was high
`timescale 1ns/1ps
module fir_host_chk import fir_ctrl_pkg::*; (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic       cmd_done,
  input wire logic       run,
  input wire logic       mux_enable,
  input wire logic [4:0] coef_base,
  input wire logic [4:0] dec_factor,
  input wire logic       odd_mode,
  input wire logic [8:0] cfg_addr,
  input wire logic [9:0] cfg_data_in,
  input wire logic       cfg_wr_n,
  input wire strobe_t    strobes
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic       run_q;
  wire        sk  = strobes.accum_keep;
  wire  [4:0] sel = strobes.coef_set_select;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) run_q <= 1'b0;
    else run_q <= run;
  end
  wr_pulse_a:
    assert property ($fell(cfg_wr_n) |=> cfg_wr_n)
    else $error("write strobe low too long");
  done_lat_a:
    assert property (cmd_valid && cmd_ready |-> ##4 cmd_done)
    else $error("done not 4 cycles after take");
  ready_gap_a:
    assert property (cmd_valid && cmd_ready |=> !cmd_ready [*3] ##1 cmd_ready)
    else $error("ready timing wrong");
  pins_hold_a:
    assert property (!cfg_wr_n |-> $stable(cfg_addr) && $stable(cfg_data_in))
    else $error("pins moved during write");
  even_swap_a:
    assert property (run_q && !odd_mode |->
      strobes.lifo_swap_strobe == (!sk && dec_factor > 5'd1))
    else $error("swap phase");
  odd_swap_a:
    assert property (run_q && $past(run_q) && odd_mode && dec_factor > 5'd1 && !sk
      |-> $past(strobes.lifo_swap_strobe))
    else $error("odd swap not one clock early");
  keep_per_a:
    assert property (run_q && !sk && dec_factor == 5'd3 |=>
      (sk || !run_q) [*2] ##1 (!sk || !run_q))
    else $error("keep period");
  coef_step_a:
    assert property (run_q && $past(run_q) && sk |-> sel == $past(sel) + 5'd1)
    else $error("set select step");
  coef_start_a:
    assert property (run_q && !sk |-> sel == $past(coef_base))
    else $error("set select start");
  mux_alt_a:
    assert property (run_q && $past(run_q) && $past(mux_enable) && !$past(sk)
      && dec_factor > 5'd1 |-> strobes.output_select != $past(strobes.output_select))
    else $error("mux not alternating");
  gates_low_a:
    assert property (!(strobes.shift_hold | strobes.fwd_path_gate | strobes.rev_path_gate))
    else $error("gate pin high");
  cover property (run_q && odd_mode && strobes.lifo_swap_strobe);
  cover property (run_q && $past(mux_enable) && !sk);
  cover property (cmd_valid && cmd_ready);
endmodule // fir_host_chk

bind fir_host_ctrl fir_host_chk chk (.*);

/* tb/fir_dev_model.sv */
// Purpose: write-only register model of the filter device
// Assumes: device latches on the rising write strobe
// Notes:   read back only by hierarchical reference
`timescale 1ns/1ps
module fir_dev_model import fir_ctrl_pkg::*; (
  input wire logic       clock,
  input wire logic [8:0] cfg_addr,
  input wire logic [9:0] cfg_data_in,
  input wire logic       cfg_wr_n,
  input wire strobe_t    strobes
);
  logic [9:0] cfg_word;
  logic [9:0] opt_word;
  logic [9:0] coef [0:255];
  logic       lifo_sel = 1'b0;
  logic       swap_d = 1'b0;
  wire  [4:0] n_dec  = cfg_word[3:0] + 5'h1;
  wire        rev_on = !opt_word[4];
  wire        odd    = !(cfg_word[6] & cfg_word[7]);
  always @(posedge cfg_wr_n) begin
    if (cfg_addr[8]) coef[cfg_addr[7:0]] <= cfg_data_in;
    else if (cfg_addr == 9'h001) opt_word <= cfg_data_in;
    else cfg_word <= cfg_data_in;
  end
  // odd length: swap acts one clock late
  always @(posedge clock) begin
    swap_d <= strobes.lifo_swap_strobe;
    if (odd ? swap_d : strobes.lifo_swap_strobe) lifo_sel <= !lifo_sel;
  end
endmodule // fir_dev_model

/* tb/fir_host_ctrl_test.sv */
// Purpose: write port and strobe sequencer tests
// Assumes: inputs driven on the falling edge
// Notes:   coefficient base held at 4 during runs
`timescale 1ns/1ps
`include "fir_ctrl_map.svh"
module fir_host_ctrl_test import fir_ctrl_pkg::*;;
  logic       clock = 0, rst = 1, cmd_valid = 0, run = 0, mux_enable = 0;
  logic [1:0] cmd_kind = 0, fixed_select = 2'h3;
  logic [8:0] cmd_addr = 0, cfg_addr;
  logic [9:0] cmd_data = 0, cfg_data_in;
  logic [4:0] coef_base = 5'h4, dec_factor;
  logic       cmd_ready, cmd_done, odd_mode, cfg_wr_n;
  strobe_t    strobes;
  int         n_errors = 0, checks_done = 0;
  fir_host_ctrl DUT (.*);
  fir_dev_model m (.*);
  initial forever #20 clock = !clock;
  task results;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string s, input logic [9:0] e, input logic [9:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task wr(input logic [1:0] k, input logic [8:0] a, input logic [9:0] d);
    int i;
    cmd_kind = k;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1;
    @(negedge clock) cmd_valid = 0;
    for (i = 0; i < 8 && cmd_done !== 1'b1; i++) @(negedge clock);
    chk("done", 3, i);
  endtask
  task go(input string s, input logic [9:0] c, input logic mx, input int ph);
    wr(0, 9'h000, c);
    mux_enable = mx;
    run = 1;
    for (int k = 0; k < 6; k++) begin
      @(negedge clock);
      chk("keep", k % 3 != 0, strobes.accum_keep);
      chk("swap", k % 3 == ph, strobes.lifo_swap_strobe);
      chk("sel", 4 + k % 3, strobes.coef_set_select);
      chk("osel", mx ? (k % 3 ? `OUT_SEL_CELL_A : `OUT_SEL_CELL_B) : 3,
          strobes.output_select);
    end
    run = 0;
    @(negedge clock);
    $display("%s run done", s);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    @(negedge clock) rst = 0;
    wr(0, 9'h000, `CFG_WORD_EVEN_DEC3);
    chk("cfg", 10'h1d2, m.cfg_word);
    chk("dec", 3, dec_factor);
    wr(0, 9'h001, 0);
    chk("rev", 1, m.rev_on);
    for (int s = 0; s < 3; s++) for (int i = 0; i < 8; i++) begin
      wr(1, 9'(s * 8 + i), 10'(s * 16 + i + 1));
      chk("coef", 10'(s * 16 + i + 1), m.coef[s * 8 + i]);
    end
    wr(1, 9'h007, 10'h0c8 >> 1);
    chk("centre", 10'h064, m.coef[7]);
    $display("config done");
    go("even", `CFG_WORD_EVEN_DEC3, 0, 0);
    go("odd", `CFG_WORD_ODD_DEC3, 0, 2);
    chk("odd", 1, odd_mode);
    go("mux", `CFG_WORD_MUX_DEC3, 1, 2);
    wr(2, 0, 16);
    chk("field", 10'h00f, m.cfg_word);
    chk("max", 16, dec_factor);
    $display("field done");
    results;
  end
  initial begin
    #50us;
    n_errors++;
    results;
  end
endmodule // fir_host_ctrl_test
